// *** design/tswg_pkg.sv ***
// Constants and types for the wheel-phased sync generator
// Function
// - All timing from one 1,006,992 Hz master tick
// - Every stage synchronous, no ripple counting
// - Deflection, blanking, clamp, mixed sync outputs
// - Converter sync at half line rate
// - Split-phase 420 Hz wheel motor drive
// - Compare wheel flag timing against vertical sync
// - Misphased flag makes motor counter skip one
// - One skip at the next step, however many misphased flags came before it
// - Correct phase arms no further skip, normal counting
// - Sync counters independent of motor counter
// - Colour flag gate on line 18, green
// - Line 17 tag for control unit
// - 60 Hz vertical signal for control unit
// - Horizontal rate sync for control unit
// - Wheel phase found automatically, then held
// - 525 lines per frame, 2:1 interlace
// - Field colours cycle red, blue, green
// - Motor drive phases offset 90 degrees
`default_nettype none
package tswg_pkg;
  localparam int unsigned CLOCK_HZ = 125000000;
  localparam int unsigned MASTER_HZ = 1006992;
  localparam logic [27:0] ACC_MOD = 28'(CLOCK_HZ);
  localparam logic [27:0] ACC_INC = 28'(MASTER_HZ);
  localparam logic [5:0] H_LAST = 6'h3f;           // 64 master ticks per line
  localparam logic [4:0] HALF_LAST = 5'h1f;        // 32 ticks per half-line
  localparam logic [9:0] FIELD_LAST = 10'h20c;     // 525 half-lines per field
  localparam logic [5:0] HBLANK_END = 6'h0b;       // Blanking 0.172 H
  localparam logic [5:0] HSYNC_BEGIN = 6'h01;
  localparam logic [5:0] HSYNC_END = 6'h06;
  localparam logic [5:0] CLAMP_BEGIN = 6'h07;
  localparam logic [4:0] SERRATION = 5'h1b;        // Broad pulse ends near half-line end
  localparam logic [9:0] VSYNC_BEGIN = 10'h006;
  localparam logic [9:0] VSYNC_END = 10'h00c;
  localparam logic [9:0] VBLANK_END = 10'h028;     // 20 lines of vertical blanking
  localparam logic [8:0] LINE_TAG = 9'h010;        // Line 17, counted from zero
  localparam logic [8:0] LINE_FLAG = 9'h011;       // Line 18, counted from zero
  localparam logic [9:0] FLAG_WINDOW = 10'h00c;    // Accept flags up to end of vsync
  localparam logic [9:0] MOTOR_DIV_LAST = 10'h257; // 600 ticks per quarter, ~420 Hz

  typedef enum logic [1:0] {
    TSWG_RED   = 2'h0,
    TSWG_BLUE  = 2'h1,
    TSWG_GREEN = 2'h3
  } tswg_color_type;

  typedef enum logic [1:0] {
    TSWG_SEARCH = 2'h0,
    TSWG_LOCKED = 2'h1
  } tswg_phase_type;

  typedef struct packed {
    logic h_drive;
    logic v_drive;
    logic sensor_blank;
    logic clamp;
    logic mixed_sync;
    logic mixed_blank;
  } tswg_video_type;

  typedef struct packed {
    logic converter_sync;
    logic ccu_vertical;
    logic ccu_horizontal;
    logic ccu_line_tag;
    logic color_flag_gate;
  } tswg_aux_type;

  typedef struct packed {
    logic drive_a;
    logic drive_b;
    logic phase_locked;
  } tswg_motor_type;
endpackage : tswg_pkg
`default_nettype wire

// *** design/tswg_top.sv ***
// Sync generator with colour-wheel motor phasing
`timescale 1ns/1ns
`default_nettype none
module tswg_top
  import tswg_pkg::*;
(
  input  wire logic              clock,      // 125 MHz system clock
  input  wire logic              reset_n,    // Asynchronous reset, active low
  input  wire logic              wheel_flag, // Optical pickup flag, synchronous
  output var  tswg_pkg::tswg_video_type video, // Deflection, blanking, sync
  output var  tswg_pkg::tswg_aux_type   aux,   // Converter and control unit timing
  output var  tswg_pkg::tswg_motor_type motor  // Wheel motor drive and lock
);
  import tswg_pkg::*;

  typedef struct packed {
    logic [27:0]    acc;
    logic           tick;
    logic [5:0]     h_tick;
    logic [9:0]     half_line;
    logic           odd_field;
    tswg_color_type color;
    logic [9:0]     motor_div;
    logic [1:0]     quarter;
    logic           skip;
    logic           flag_prev;
    tswg_phase_type phase;
    tswg_video_type video;
    tswg_aux_type   aux;
    tswg_motor_type motor;
  } tswg_state_type;

  tswg_state_type state;
  tswg_state_type next_state;

  function automatic logic in_range(input logic [9:0] v, input logic [9:0] lo, input logic [9:0] hi);
    in_range = (v >= lo) && (v < hi);
  endfunction : in_range

  logic [8:0] line_index;
  logic       flag_edge;
  logic       flag_good;
  logic       vsync_area;
  logic       field_wrap;
  logic       motor_step;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_state = state;
    // Fractional accumulator keeps the master rate exact on a 125 MHz clock
    next_state.tick = 1'b0;
    if ({1'b0, state.acc} + {1'b0, ACC_INC} >= {1'b0, ACC_MOD})
    begin
      next_state.acc = state.acc + ACC_INC - ACC_MOD;
      next_state.tick = 1'b1;
    end
    else
    begin
      next_state.acc = state.acc + ACC_INC;
    end

    // Line and field counting only ever sees the master tick, never the wheel
    field_wrap = state.tick && (state.h_tick[4:0] == HALF_LAST) && (state.half_line == FIELD_LAST);
    if (state.tick)
    begin
      next_state.h_tick = (state.h_tick == H_LAST) ? 6'h00 : state.h_tick + 6'h01;
      if (state.h_tick[4:0] == HALF_LAST)
      begin
        next_state.half_line = (state.half_line == FIELD_LAST) ? 10'h000 : state.half_line + 10'h001;
      end
    end
    if (field_wrap)
    begin
      next_state.odd_field = ~state.odd_field;
      case (state.color)
        TSWG_RED:   next_state.color = TSWG_BLUE;
        TSWG_BLUE:  next_state.color = TSWG_GREEN;
        TSWG_GREEN: next_state.color = TSWG_RED;
        default:    next_state.color = TSWG_RED;
      endcase
    end

    // Timing outputs decoded from the counters
    line_index = state.half_line[9:1];
    vsync_area = in_range(state.half_line, VSYNC_BEGIN, VSYNC_END);
    next_state.video.h_drive = (state.h_tick >= HSYNC_BEGIN) && (state.h_tick < HSYNC_END);
    next_state.video.v_drive = vsync_area;
    next_state.video.mixed_blank = (state.h_tick < HBLANK_END) || (state.half_line < VBLANK_END);
    next_state.video.sensor_blank = next_state.video.mixed_blank;
    next_state.video.clamp = (state.h_tick >= CLAMP_BEGIN) && (state.h_tick < HBLANK_END)
                             && (state.half_line >= VBLANK_END);
    // Serrated broad pulses keep horizontal lock through vertical sync
    next_state.video.mixed_sync = vsync_area ? (state.h_tick[4:0] < SERRATION) : next_state.video.h_drive;
    if (state.tick && (state.h_tick == H_LAST))
    begin
      next_state.aux.converter_sync = ~state.aux.converter_sync;
    end
    next_state.aux.ccu_vertical = vsync_area;
    next_state.aux.ccu_horizontal = next_state.video.h_drive;
    next_state.aux.ccu_line_tag = (line_index == LINE_TAG);
    next_state.aux.color_flag_gate = (state.color == TSWG_GREEN) && (line_index == LINE_FLAG)
                                     && (state.h_tick >= HBLANK_END);

    // Phase comparator: a flag edge must land early in a green field
    next_state.flag_prev = wheel_flag;
    flag_edge = wheel_flag && !state.flag_prev;
    flag_good = (state.color == TSWG_GREEN) && (state.half_line < FLAG_WINDOW);
    case (state.phase)
      TSWG_SEARCH: if (flag_edge && flag_good) next_state.phase = TSWG_LOCKED;
      TSWG_LOCKED: if (flag_edge && !flag_good) next_state.phase = TSWG_SEARCH;
      default:     next_state.phase = TSWG_SEARCH;
    endcase
    next_state.motor.phase_locked = (next_state.phase == TSWG_LOCKED);

    // Motor quarter-cycle divider; a skip holds the quarter for one extra step
    motor_step = 1'b0;
    if (state.tick)
    begin
      if (state.motor_div == MOTOR_DIV_LAST)
      begin
        next_state.motor_div = 10'h000;
        motor_step = 1'b1;
      end
      else
      begin
        next_state.motor_div = state.motor_div + 10'h001;
      end
    end
    if (motor_step)
    begin
      if (state.skip)
      begin
        next_state.skip = 1'b0;
      end
      else
      begin
        next_state.quarter = state.quarter + 2'h1;
      end
    end
    // A new misphased flag wins over the clear of a pending skip
    if (flag_edge && !flag_good)
    begin
      next_state.skip = 1'b1;
    end
    next_state.motor.drive_a = next_state.quarter[1];
    next_state.motor.drive_b = next_state.quarter[1] ^ next_state.quarter[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign video = state.video;
  assign aux = state.aux;
  assign motor = state.motor;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  property p_tick_spacing;
    state.tick |=> !state.tick [*8];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("master ticks too close");

  property p_line_wrap;
    state.tick && (state.h_tick == H_LAST) |=> (state.h_tick == 6'h00);
  endproperty
  a_line_wrap: assert property (p_line_wrap) else $error("line counter did not wrap at 64");

  property p_field_wrap;
    field_wrap |=> (state.half_line == 10'h000) && (state.odd_field != $past(state.odd_field));
  endproperty
  a_field_wrap: assert property (p_field_wrap) else $error("field did not end after 525 half-lines");

  property p_color_order;
    field_wrap && (state.color == TSWG_GREEN) |=> (state.color == TSWG_RED);
  endproperty
  a_color_order: assert property (p_color_order) else $error("green not followed by red");

  sequence s_misphase;
    flag_edge && !flag_good;
  endsequence
  property p_skip_set;
    s_misphase |=> state.skip && (state.phase == TSWG_SEARCH);
  endproperty
  a_skip_set: assert property (p_skip_set) else $error("misphased flag did not arm a skip");

  property p_skip_hold;
    motor_step && state.skip && !(flag_edge && !flag_good) |=> $stable(state.quarter) && !state.skip;
  endproperty
  a_skip_hold: assert property (p_skip_hold) else $error("skip not exactly one count");

  property p_quadrature;
    $changed(motor.drive_a) |-> $stable(motor.drive_b);
  endproperty
  a_quadrature: assert property (p_quadrature) else $error("motor phases changed together");

  property p_sync_independent;
    state.tick && (state.h_tick != H_LAST) |=> (state.h_tick == $past(state.h_tick) + 6'h01);
  endproperty
  a_sync_independent: assert property (p_sync_independent) else $error("line counter stalled");

  property p_flag_green;
    aux.color_flag_gate |-> (state.color == TSWG_GREEN);
  endproperty
  a_flag_green: assert property (p_flag_green) else $error("colour flag outside green field");
endmodule : tswg_top
`default_nettype wire

// *** verification/tswg_wheel_sensor.sv ***
// Behavioural wheel light sensor that lights the flag line on request
`timescale 1ns/1ns
`default_nettype none
module tswg_wheel_sensor #(
  parameter int FLAG_LEN = 4 // Clocks the pickup stays lit per rim hole
) (
  input  wire logic clock,     // System clock
  input  wire logic reset_n,   // Asynchronous reset, active low
  input  wire logic fire,      // Request one flag pulse
  output var  logic wheel_flag // Flag pulse to the generator
);
  int count;

  ////////////////////////////////////////////////////////////////////////////
  // A phased wheel would flag at green start; the bench chooses when instead
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      count <= 0;
    else if (fire)
      count <= FLAG_LEN;
    else if (count != 0)
      count <= count - 1;
  end

  assign wheel_flag = (count != 0);
endmodule : tswg_wheel_sensor
`default_nettype wire

// *** verification/tswg_top_tb.sv ***
// Self-checking bench for the wheel-phased sync generator
`timescale 1ns/1ns
`default_nettype none
`define CHECK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("Error at %0t ns: got %0h expected %0h", $time, (got), (exp)); \
    end \
  end
module tswg_top_tb;
  import tswg_pkg::*;
  logic           clock;
  logic           reset_n;
  logic           fire;
  logic           wheel_flag;
  tswg_video_type video;
  tswg_aux_type   aux;
  tswg_motor_type motor;
  logic [13:0]    outs;
  int             fails;
  int             compares;
  int             cyc = 0;
  int             t_h;

  assign outs = {video, aux, motor};

  tswg_top u_tswg_top (.clock(clock), .reset_n(reset_n), .wheel_flag(wheel_flag),
                       .video(video), .aux(aux), .motor(motor));
  tswg_wheel_sensor u_tswg_wheel_sensor (.clock(clock), .reset_n(reset_n), .fire(fire),
                                         .wheel_flag(wheel_flag));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  always @(posedge clock) cyc <= reset_n ? cyc + 1 : 0;

  // Master ticks land on 124 or 125 clocks, so allow one clock of jitter early and two late
  function automatic logic near(input int n, input int k);
    longint e;
    e = longint'(k) * CLOCK_HZ / MASTER_HZ;
    return (n >= e - 1) && (n <= e + 2);
  endfunction : near

  task automatic wait_bit(input int b, input logic v);
    while (outs[b] !== v) @(negedge clock);
  endtask : wait_bit

  task automatic end_of_test;
    if (fails == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////
  task automatic check_line;
    int t0;
    logic cs;
    wait_bit(13, 1'b0);
    wait_bit(13, 1'b1);
    t0 = cyc;
    cs = aux.converter_sync;
    if (t_h == 0)
      t_h = t0;
    `CHECK(aux.ccu_horizontal, 1'b1)
    `CHECK(video.mixed_sync, 1'b1)
    wait_bit(13, 1'b0);
    `CHECK(near(cyc - t0, int'(HSYNC_END) - int'(HSYNC_BEGIN)), 1'b1)
    `CHECK(aux.ccu_horizontal, 1'b0)
    `CHECK(video.mixed_sync, 1'b0)
    `CHECK(video.clamp, 1'b0)
    `CHECK(video.mixed_blank, 1'b1)
    `CHECK(video.sensor_blank, 1'b1)
    wait_bit(13, 1'b1);
    `CHECK(near(cyc - t0, int'(H_LAST) + 1), 1'b1)
    `CHECK(aux.converter_sync, ~cs)
  endtask : check_line

  // Flags in a red field are misphased and must never report lock
  task automatic check_flag;
    repeat (2)
    begin
      fire = 1'b1;
      @(negedge clock);
      fire = 1'b0;
      repeat (6) @(negedge clock);
      `CHECK(motor.phase_locked, 1'b0)
    end
  endtask : check_flag

  task automatic check_vertical;
    int t0;
    wait_bit(12, 1'b1);
    `CHECK(near(cyc - t_h, int'(VSYNC_BEGIN) * (int'(HALF_LAST) + 1) - 1), 1'b1)
    `CHECK(aux.ccu_vertical, 1'b1)
    `CHECK(video.mixed_sync, 1'b1)
    t0 = cyc;
    // Broad pulse drops for the serration, then returns on the next half-line
    wait_bit(9, 1'b0);
    `CHECK(near(cyc - t0, int'(SERRATION)), 1'b1)
    `CHECK(video.v_drive, 1'b1)
    wait_bit(9, 1'b1);
    `CHECK(near(cyc - t0, int'(HALF_LAST) + 1), 1'b1)
    wait_bit(12, 1'b0);
    `CHECK(near(cyc - t0, (int'(VSYNC_END) - int'(VSYNC_BEGIN)) * (int'(HALF_LAST) + 1)), 1'b1)
    `CHECK(aux.ccu_vertical, 1'b0)
  endtask : check_vertical

  // Unskipped, the first quarter step would raise drive_b here
  task automatic check_motor;
    longint step;
    step = longint'(int'(MOTOR_DIV_LAST) + 1) * CLOCK_HZ / MASTER_HZ;
    while (cyc < step + 2000) @(negedge clock);
    `CHECK(motor.drive_a, 1'b0)
    `CHECK(motor.drive_b, 1'b0)
  endtask : check_motor

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    reset_n = 1'b0;
    fire = 1'b0;
    fails = 0;
    compares = 0;
    t_h = 0;
    repeat (3) @(negedge clock);
    `CHECK(outs, 14'h0000)
    reset_n = 1'b1;
    check_line();
    check_flag();
    check_vertical();
    check_line();
    check_motor();
    end_of_test();
  end

  initial
  begin
    repeat (90000) @(posedge clock);
    fails++;
    end_of_test();
  end
endmodule : tswg_top_tb
`default_nettype wire
